// File: verilog/urss_pkg.sv
package urss_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // register offsets on the plain register port (byte offsets)
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_SCR = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL = 3'h0;
  // reset values
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INT_STATUS = 8'h01;
  localparam logic [7:0] RST_LINE_CTRL = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RST_LINE_STATUS = 8'h60;
  localparam logic [7:0] RST_FIFO_CTRL = 8'h00;
  localparam logic [7:0] RST_SCR = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // field positions
  localparam int INT_ENABLE_MODEM_BIT = 3;
  localparam int INT_STATUS_NOPEND_BIT = 0;
  localparam int MODEM_CTRL_DTR_BIT = 0;
  localparam int MODEM_CTRL_RTS_BIT = 1;
  localparam int RING_BIT = 2;
  localparam logic [3:0] INT_CODE_MODEM = 4'h0;
  localparam logic [3:0] INT_CODE_NONE = 4'h1;
  // edges after reset release before the change detector trusts its history
  localparam logic [1:0] TRACK_ARM_COUNT = 2'h3;
endpackage

// File: verilog/urss_modem_if.sv
interface urss_modem_if;
  logic [3:0] pinLevel;
  logic [3:0] deltaBits;
  logic clearDelta;
  modport tracker (input clearDelta, output pinLevel, output deltaBits);
  modport owner (input pinLevel, input deltaBits, output clearDelta);
endinterface

// File: verilog/urss_modem_track.sv
module urss_modem_track
  import urss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] modemPins,
  urss_modem_if.tracker mif
);
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] prev_r;
  logic [3:0] delta_r;
  logic [1:0] armCnt_r;
  logic armed;
  // the first compare after reset sees the synchroniser's zero, not the pins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armCnt_r <= 2'h0;
    end else if (armCnt_r != TRACK_ARM_COUNT) begin
      armCnt_r <= armCnt_r + 2'h1;
    end
  end
  assign armed = (armCnt_r == TRACK_ARM_COUNT);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= modemPins;
      sync2_r <= sync1_r;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 4'h0;
    end else begin
      prev_r <= sync2_r;
    end
  end
  // set wins over a read-clear in the same cycle; index 2 counts trailing edge only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_delta
      logic evt;
      assign evt = armed & ((gi == RING_BIT) ? (prev_r[gi] & ~sync2_r[gi]) : (prev_r[gi] ^ sync2_r[gi]));
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          delta_r[gi] <= 1'b0;
        end else if (evt) begin
          delta_r[gi] <= 1'b1;
        end else if (mif.clearDelta) begin
          delta_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign mif.pinLevel = sync2_r;
  assign mif.deltaBits = delta_r;
endmodule // urss_modem_track

// File: verilog/urss_reset_regs.sv
// Function
// - an 8-bit scratch byte, written and read back, with no effect elsewhere
// - reset clears interrupt-enable, line-control, modem-control and fifo-control to zero
// - reset makes interrupt-status read 0x01: nothing pending
// - reset makes line-status read bits 6 and 5 set, all others zero
// - reset clears modem change bits; upper modem bits follow the pins
// - reset drives tx, rts, dtr, receive dma high and transmit dma low
// - any modem change bit set raises the modem interrupt when enabled
module urss_reset_regs
  import urss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic [3:0] modemPins,
  output logic serialTx,
  output logic rtsN,
  output logic dtrN,
  output logic receive_dma_request,
  output logic transmit_dma_request,
  output logic irqOut
);
  logic [7:0] interrupt_enable_reg_r;
  logic [7:0] line_control_reg_r;
  logic [7:0] modem_control_reg_r;
  logic [7:0] fifo_control_reg_r;
  logic [7:0] user_scratch_byte_r;
  logic [7:0] line_status_reg_r;
  logic [7:0] rdata_nxt;
  logic [7:0] interrupt_status_reg;
  logic [7:0] modem_status_reg;
  logic modemIrq;
  urss_modem_if mif ();

  urss_modem_track u_track (
    .core_clk(core_clk),
    .rstn(rstn),
    .modemPins(modemPins),
    .mif(mif)
  );

  assign modem_status_reg = {mif.pinLevel, mif.deltaBits};
  assign modemIrq = (|mif.deltaBits) & interrupt_enable_reg_r[INT_ENABLE_MODEM_BIT];
  assign interrupt_status_reg = {4'h0, modemIrq ? INT_CODE_MODEM : INT_CODE_NONE};
  // reading the modem status clears its change bits
  assign mif.clearDelta = regRead && (regAddr == ADDR_MODEM_STATUS);

  // one process per control register, each cleared by reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_reg_r <= RST_INT_ENABLE;
    end else if (regWrite && regAddr == ADDR_INT_ENABLE) begin
      interrupt_enable_reg_r <= regWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_control_reg_r <= RST_LINE_CTRL;
    end else if (regWrite && regAddr == ADDR_LINE_CTRL) begin
      line_control_reg_r <= regWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modem_control_reg_r <= RST_MODEM_CTRL;
    end else if (regWrite && regAddr == ADDR_MODEM_CTRL) begin
      modem_control_reg_r <= regWdata;
    end
  end

  // write-only: reads at this offset return zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_control_reg_r <= RST_FIFO_CTRL;
    end else if (regWrite && regAddr == ADDR_FIFO_CTRL) begin
      fifo_control_reg_r <= regWdata;
    end
  end

  // cleared for a consistent state; no function depends on it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      user_scratch_byte_r <= RST_SCR;
    end else if (regWrite && regAddr == ADDR_SCR) begin
      user_scratch_byte_r <= regWdata;
    end
  end

  // no serial engine here: line status holds its idle value
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_status_reg_r <= RST_LINE_STATUS;
    end else begin
      line_status_reg_r <= RST_LINE_STATUS;
    end
  end

  always_comb begin
    rdata_nxt = ZERO_BYTE;
    case (regAddr)
      ADDR_INT_ENABLE: rdata_nxt = interrupt_enable_reg_r;
      ADDR_INT_STATUS: rdata_nxt = interrupt_status_reg;
      ADDR_LINE_CTRL: rdata_nxt = line_control_reg_r;
      ADDR_MODEM_CTRL: rdata_nxt = modem_control_reg_r;
      ADDR_LINE_STATUS: rdata_nxt = line_status_reg_r;
      ADDR_MODEM_STATUS: rdata_nxt = modem_status_reg;
      ADDR_SCR: rdata_nxt = user_scratch_byte_r;
      default: rdata_nxt = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= ZERO_BYTE;
    end else if (regRead) begin
      regRdata <= rdata_nxt;
    end else begin
      regRdata <= ZERO_BYTE;
    end
  end

  // pin outputs follow the inverted modem-control bits; all idle after reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rtsN <= 1'b1;
    end else begin
      rtsN <= ~modem_control_reg_r[MODEM_CTRL_RTS_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dtrN <= 1'b1;
    end else begin
      dtrN <= ~modem_control_reg_r[MODEM_CTRL_DTR_BIT];
    end
  end

  // no serial engine or dma logic here: these pins hold their idle levels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serialTx <= 1'b1;
      receive_dma_request <= 1'b1;
      transmit_dma_request <= 1'b0;
    end else begin
      serialTx <= 1'b1;
      receive_dma_request <= 1'b1;
      transmit_dma_request <= 1'b0;
    end
  end

  // registered so the pin never glitches while change bits settle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= modemIrq;
    end
  end

  chk_scratch_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == ADDR_SCR ##1 regRead && regAddr == ADDR_SCR && !regWrite
    |=> regRdata == $past(regWdata, 2)) else $error("scratch readback mismatch");
  // reset values are looked at on the first edge after release
  chk_ctrl_reset_zero: assert property (@(posedge core_clk)
    $rose(rstn) |-> interrupt_enable_reg_r == RST_INT_ENABLE && line_control_reg_r == RST_LINE_CTRL
    && modem_control_reg_r == RST_MODEM_CTRL && fifo_control_reg_r == RST_FIFO_CTRL)
    else $error("control not cleared");
  chk_isr_idle_value: assert property (@(posedge core_clk) disable iff (!rstn)
    (mif.deltaBits == 4'h0) |-> interrupt_status_reg[INT_STATUS_NOPEND_BIT] && interrupt_status_reg[7:1] == 7'h00)
    else $error("status not idle");
  chk_lsr_reset_value: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == ADDR_LINE_STATUS |=> regRdata == RST_LINE_STATUS) else $error("line status wrong");
  chk_msr_change_clear: assert property (@(posedge core_clk)
    $rose(rstn) |-> mif.deltaBits == 4'h0) else $error("change bits not cleared");
  chk_msr_upper_pins: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == ADDR_MODEM_STATUS |=> regRdata[7:4] == $past(mif.pinLevel))
    else $error("pin levels wrong");
  chk_idle_outputs: assert property (@(posedge core_clk)
    $rose(rstn) |-> serialTx && rtsN && dtrN && receive_dma_request && !transmit_dma_request)
    else $error("reset outputs wrong");
  chk_modem_irq_raise: assert property (@(posedge core_clk) disable iff (!rstn)
    (|mif.deltaBits) && interrupt_enable_reg_r[INT_ENABLE_MODEM_BIT] |=> irqOut)
    else $error("modem irq missing");
  chk_scratch_reset: assert property (@(posedge core_clk)
    $rose(rstn) |-> user_scratch_byte_r == RST_SCR) else $error("scratch not cleared");

  // running checks: outputs and status between accesses
  chk_rts_ctrl_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    !modem_control_reg_r[MODEM_CTRL_RTS_BIT] |=> rtsN)
    else $error("rts not idle");
  chk_dtr_ctrl_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    !modem_control_reg_r[MODEM_CTRL_DTR_BIT] |=> dtrN)
    else $error("dtr not idle");
  chk_fixed_line_outputs: assert property (@(posedge core_clk) disable iff (!rstn)
    serialTx && receive_dma_request && !transmit_dma_request)
    else $error("fixed outputs moved");
  chk_isr_modem_code: assert property (@(posedge core_clk) disable iff (!rstn)
    modemIrq |-> !interrupt_status_reg[INT_STATUS_NOPEND_BIT])
    else $error("pending modem irq not shown");
  chk_irq_needs_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    !interrupt_enable_reg_r[INT_ENABLE_MODEM_BIT] |=> !irqOut)
    else $error("irq without enable");
  chk_irq_drops_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    !(|mif.deltaBits) |=> !irqOut)
    else $error("irq without change");
  chk_msr_change_read: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == ADDR_MODEM_STATUS |=> regRdata[3:0] == $past(mif.deltaBits))
    else $error("change bits read wrong");
  chk_scratch_holds_value: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == ADDR_SCR) |=> $stable(user_scratch_byte_r))
    else $error("scratch changed without write");
  chk_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRead |=> regRdata == ZERO_BYTE)
    else $error("read data not idle");

  cov_scratch_write: cover property (@(posedge core_clk) disable iff (!rstn) regWrite && regAddr == ADDR_SCR);
  cov_modem_irq: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irqOut));
  cov_msr_read_clear: cover property (@(posedge core_clk) disable iff (!rstn) mif.clearDelta && |mif.deltaBits);
  cov_ctrl_write: cover property (@(posedge core_clk) disable iff (!rstn) regWrite && regAddr == ADDR_MODEM_CTRL);
  cov_reset_release: cover property (@(posedge core_clk) $rose(rstn));
endmodule // urss_reset_regs

// File: testbench/urss_modem_model.sv
module urss_modem_model (
  input wire logic core_clk,
  input wire logic [3:0] pinCmd,
  output logic [3:0] modemPins
);
  timeunit 1ns;
  timeprecision 1ps;
  // a modem line driver: pins move a cycle after the command, never left floating
  initial modemPins = 4'h0;
  always @(posedge core_clk) begin
    modemPins <= pinCmd;
  end
endmodule // urss_modem_model

// File: testbench/urss_reset_regs_tb.sv
module urss_reset_regs_tb
  import urss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] regAddr = 3'h0;
  logic [DATA_W-1:0] regWdata = 8'h00;
  logic [DATA_W-1:0] regRdata;
  logic [DATA_W-1:0] rdv;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] modemPins;
  logic [3:0] pinCmd = 4'h0;
  logic serialTx, rtsN, dtrN, rxDma, txDma, irqOut;
  logic [7:0] outs;
  int mismatches = 0;
  int cmp_count = 0;
  logic [ADDR_W-1:0] rAddr [6] = '{ADDR_INT_ENABLE, ADDR_INT_STATUS, ADDR_LINE_CTRL, ADDR_MODEM_CTRL,
    ADDR_LINE_STATUS, ADDR_SCR};
  logic [7:0] rExp [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00};
  logic [3:0] pinSeq [4] = '{4'hB, 4'h9, 4'h5, 4'h1};
  logic [7:0] msrExp [4] = '{8'hB1, 8'h92, 8'h58, 8'h14};
  assign outs = {2'b00, serialTx, rtsN, dtrN, rxDma, txDma, irqOut};
  initial forever #12.5 core_clk = ~core_clk;
  urss_modem_model modem (.core_clk(core_clk), .pinCmd(pinCmd), .modemPins(modemPins));
  urss_reset_regs dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .modemPins(modemPins),
    .serialTx(serialTx), .rtsN(rtsN), .dtrN(dtrN), .receive_dma_request(rxDma),
    .transmit_dma_request(txDma), .irqOut(irqOut));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // pins are not compared on the low nibble here: the synchroniser restarts from zero
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("outputs in reset", outs, 8'h3C);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("outputs after reset", outs, 8'h3C);
    for (int i = 0; i < 6; i++) begin
      rd(rAddr[i]);
      chk("reset value", rdv, rExp[i]);
    end
    rd(ADDR_MODEM_STATUS);
    chk("modem status high", rdv & 8'hF0, {pinCmd, 4'h0});
  endtask
  initial begin
    do_reset();
    wr(ADDR_SCR, 8'hA5);
    rd(ADDR_SCR);
    chk("scratch", rdv, 8'hA5);
    wr(ADDR_SCR, 8'h5A);
    rd(ADDR_SCR);
    chk("scratch", rdv, 8'h5A);
    rd(ADDR_LINE_STATUS);
    chk("line status", rdv, 8'h60);
    wr(ADDR_MODEM_CTRL, 8'h01);
    // the pin flop takes the new control value one edge after the write lands
    @(posedge core_clk);
    #1;
    chk("rts dtr", {6'h00, rtsN, dtrN}, 8'h02);
    wr(ADDR_MODEM_CTRL, 8'h03);
    wr(ADDR_LINE_CTRL, 8'h55);
    wr(ADDR_INT_ENABLE, 8'h0F);
    pinCmd <= 4'hA;
    $display("test scratch and control done");
    do_reset();
    $display("test mid-run reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_INT_ENABLE, (i == 0) ? 8'h08 : 8'h00);
      pinCmd <= pinSeq[i];
      repeat (6) @(posedge core_clk);
      chk("modem irq", {7'h00, irqOut}, (i == 0) ? 8'h01 : 8'h00);
      rd(ADDR_INT_STATUS);
      chk("interrupt status", rdv, (i == 0) ? 8'h00 : 8'h01);
      rd(ADDR_MODEM_STATUS);
      chk("modem status", rdv, msrExp[i]);
      repeat (2) @(posedge core_clk);
      chk("irq after read", {7'h00, irqOut}, 8'h00);
    end
    $display("test modem change done");
    end_of_test();
  end
endmodule // urss_reset_regs_tb
